// [src/voltage_monitor_cfg.svh]
// offsets, field positions, reset values and timing counts of the voltage monitor
`ifndef VOLTAGE_MONITOR_CFG_SVH
`define VOLTAGE_MONITOR_CFG_SVH

// common registers
`define VM_OFS_EVT_LO      4'h0
`define VM_OFS_EVT_HI      4'h1
`define VM_OFS_MGMT_LO     4'h2
`define VM_OFS_MGMT_HI     4'h3
`define VM_OFS_IRQ_LO      4'h4
`define VM_OFS_IRQ_HI      4'h5
`define VM_OFS_VID         4'h6
`define VM_OFS_RATE        4'h7
`define VM_OFS_CFG         4'h8
`define VM_OFS_BANK        4'h9
// banked registers
`define VM_OFS_CH_CFG      4'ha
`define VM_OFS_CH_READ     4'hb
`define VM_OFS_CH_HIGH     4'hc
`define VM_OFS_CH_LOW      4'hd

// monitor_config fields
`define VM_CFG_MON_EN      0
`define VM_CFG_STANDBY     1
`define VM_CFG_INT_REF     2
// channel_cfg_status fields
`define VM_CH_EN           0
`define VM_CH_ALM_EN       1
`define VM_CH_HIGH_HIT     6
`define VM_CH_LOW_HIT      7
// conversion_rate fields
`define VM_RATE_PER_LSB    0
`define VM_RATE_DLY_LSB    4

// reset values
`define VM_RST_RATE        8'h00
`define VM_RST_CFG         3'h0
`define VM_RST_HIGH        8'hff
`define VM_RST_LOW         8'h00

// channel count and half-scale channels (standby, core, analog supply)
`define VM_NUM_CH          11
`define VM_HALF_MASK       11'h580

// timing
`define VM_CLK_HZ          10000000
`define VM_PERIOD_UNIT_MS  100
`define VM_DLY_UNIT_US     1
`define VM_PERIOD_UNIT_CYC (`VM_PERIOD_UNIT_MS * (`VM_CLK_HZ / 1000))
`define VM_DLY_UNIT_CYC    ((`VM_DLY_UNIT_US * `VM_CLK_HZ + 999999) / 1000000)

`endif

// [src/voltage_monitor_pkg.sv]
// types shared by the voltage monitor modules
package voltage_monitor_pkg;

	typedef struct packed {
		logic lowHit;
		logic highHit;
		logic alarmEn;
		logic chanEn;
	} chan_cfg_s;

	typedef struct packed {
		logic       valid;
		logic [3:0] chan;
		logic [7:0] data;
	} result_s;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_CONV   = 4'b0010,
		S_SETTLE = 4'b0100,
		S_SPARE  = 4'b1000
	} scan_state_e;

endpackage : voltage_monitor_pkg

// [src/voltage_scan_seq.sv]
// burst scan sequencer: period timer, channel walk and settling delay
`timescale 1ns/10ps
`default_nettype none
`include "voltage_monitor_cfg.svh"

module voltage_scan_seq
	import voltage_monitor_pkg::*;
#(
	parameter int NCH         = `VM_NUM_CH,
	parameter int PERIOD_UNIT = `VM_PERIOD_UNIT_CYC,
	parameter int DLY_UNIT    = `VM_DLY_UNIT_CYC
) (
	input  wire logic           clock,
	input  wire logic           rst_b,
	input  wire logic           run,
	input  wire logic           hold,
	input  wire logic [NCH-1:0] eligible,
	input  wire logic [2:0]     rateSel,
	input  wire logic [3:0]     dlySel,
	input  wire logic           convDone,
	input  wire logic [7:0]     convData,
	output logic                convStart,
	output logic [3:0]          convChan,
	output logic                convHalf,
	output result_s             result
);

	localparam logic [NCH-1:0] HALF = NCH'(`VM_HALF_MASK);

	scan_state_e state_reg;
	logic [31:0] periodCnt_reg;
	logic [31:0] dlyCnt_reg;
	logic [31:0] periodLen;
	logic [31:0] dlyLen;
	logic        tick;
	logic [4:0]  firstPick;
	logic [4:0]  nextPick;

	// lowest eligible channel at or above from, with a found flag on top
	function automatic logic [4:0] nextChan(input logic [NCH-1:0] m, input logic [3:0] from);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (m[i] && i >= int'(from)) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : nextChan

	assign periodLen = (32'(rateSel) + 32'h1) * 32'(PERIOD_UNIT);
	assign dlyLen    = 32'(dlySel) * 32'(DLY_UNIT);
	assign tick      = run && (periodCnt_reg == 32'h0);
	assign firstPick = nextChan(eligible, 4'h0);
	assign nextPick  = nextChan(eligible, 4'(convChan + 4'h1));

	// period timer; held at zero while not running so a restart triggers at once
	always_ff @(posedge clock) begin
		if (!rst_b || !run) begin
			periodCnt_reg <= 32'h0;
		end else if (periodCnt_reg >= periodLen - 32'h1) begin
			periodCnt_reg <= 32'h0;
		end else begin
			periodCnt_reg <= periodCnt_reg + 32'h1;
		end
	end

	// scan walk; a hold aborts the burst so no stale result lands later
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_reg  <= S_IDLE;
			convStart  <= 1'b0;
			convChan   <= 4'h0;
			convHalf   <= 1'b0;
			dlyCnt_reg <= 32'h0;
			result     <= '0;
		end else begin
			convStart    <= 1'b0;
			result.valid <= 1'b0;
			unique case (state_reg)
				S_IDLE: begin
					if (tick && !hold && firstPick[4]) begin
						convStart <= 1'b1;
						convChan  <= firstPick[3:0];
						convHalf  <= HALF[firstPick[3:0]];
						state_reg <= S_CONV;
					end
				end
				S_CONV: begin
					if (hold) begin
						state_reg <= S_IDLE;
					end else if (convDone) begin
						result     <= '{valid: 1'b1, chan: convChan, data: convData};
						dlyCnt_reg <= 32'h0;
						state_reg  <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					if (hold) begin
						state_reg <= S_IDLE;
					end else if (dlyCnt_reg < dlyLen) begin
						dlyCnt_reg <= dlyCnt_reg + 32'h1;
					end else if (nextPick[4] && convChan < 4'(NCH - 1)) begin
						convStart <= 1'b1;
						convChan  <= nextPick[3:0];
						convHalf  <= HALF[nextPick[3:0]];
						state_reg <= S_CONV;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_hold_nostart: assert property (hold |=> !convStart)
		else $error("conversion started during hold");

endmodule : voltage_scan_seq
`default_nettype wire

// [src/voltage_level_monitor_ctrl.sv]
// voltage monitor control: registers, limit checks and event outputs
`timescale 1ns/10ps
`default_nettype none
`include "voltage_monitor_cfg.svh"

module voltage_level_monitor_ctrl
	import voltage_monitor_pkg::*;
#(
	parameter int NCH         = `VM_NUM_CH,
	parameter int PERIOD_UNIT = `VM_PERIOD_UNIT_CYC,
	parameter int DLY_UNIT    = `VM_DLY_UNIT_CYC
) (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic [3:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	input  wire logic       regRdEn,
	output logic [7:0]      regRdData,
	input  wire logic       powerFailSense_b,
	input  wire logic       errorDetect,
	input  wire logic       tempIntRef,
	output logic            refInternal,
	output logic            convStart,
	output logic [3:0]      convChan,
	output logic            convHalf,
	input  wire logic       convDone,
	input  wire logic [7:0] convData,
	output logic            alarmOut,
	output logic            sysMgmtInt,
	output logic            irqOut
);

	// common registers
	logic [7:0] mgmtMaskLo_reg;
	logic [7:0] mgmtMaskHi_reg;
	logic [7:0] irqMaskLo_reg;
	logic [7:0] irqMaskHi_reg;
	logic [7:0] convRate_reg;
	logic [2:0] monCfg_reg;
	logic [3:0] bankSel_reg;

	// banked registers, one entry per channel
	chan_cfg_s  chanCfg_reg  [NCH];
	logic [7:0] readout_reg  [NCH];
	logic [7:0] highLim_reg  [NCH];
	logic [7:0] lowLim_reg   [NCH];

	// power-fail synchroniser and compare pipeline
	logic       pfMeta_reg;
	logic       pfSync_reg;
	logic       cmpPend_reg;
	logic [3:0] cmpChan_reg;

	logic            hold;
	logic            run;
	logic            bankOk;
	logic            hiViol;
	logic            loViol;
	logic [NCH-1:0]  alarmVec;
	logic [NCH-1:0]  almEnVec;
	logic [NCH-1:0]  eligible;
	logic [15:0]     eventVec;
	logic [7:0]      rdMux;
	result_s         result;

	// channel register byte as software sees it
	function automatic logic [7:0] cfgByte(input chan_cfg_s c);
		logic [7:0] b;
		b = 8'h00;
		b[`VM_CH_EN]       = c.chanEn;
		b[`VM_CH_ALM_EN]   = c.alarmEn;
		b[`VM_CH_HIGH_HIT] = c.highHit;
		b[`VM_CH_LOW_HIT]  = c.lowHit;
		return b;
	endfunction : cfgByte

	// pin crosses in two stages; a board without the signal ties it high
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pfMeta_reg <= 1'b1;
			pfSync_reg <= 1'b1;
		end else begin
			pfMeta_reg <= powerFailSense_b;
			pfSync_reg <= pfMeta_reg;
		end
	end

	assign hold   = !pfSync_reg || errorDetect;
	assign run    = monCfg_reg[`VM_CFG_MON_EN] && !monCfg_reg[`VM_CFG_STANDBY];
	assign bankOk = bankSel_reg < 4'(NCH);

	// per-channel alarm, enable and scan eligibility vectors
	always_comb begin
		eventVec = 16'h0000;
		for (int c = 0; c < NCH; c++) begin
			alarmVec[c] = chanCfg_reg[c].highHit || chanCfg_reg[c].lowHit;
			almEnVec[c] = chanCfg_reg[c].alarmEn;
			eligible[c] = chanCfg_reg[c].chanEn && !alarmVec[c];
			eventVec[c] = alarmVec[c];
		end
	end

	// limit checks use the stored readout, one cycle after it lands
	assign hiViol = readout_reg[cmpChan_reg] > highLim_reg[cmpChan_reg];
	assign loViol = readout_reg[cmpChan_reg] < lowLim_reg[cmpChan_reg];

	voltage_scan_seq #(
		.NCH         (NCH),
		.PERIOD_UNIT (PERIOD_UNIT),
		.DLY_UNIT    (DLY_UNIT)
	) u_seq (
		.clock     (clock),
		.rst_b     (rst_b),
		.run       (run),
		.hold      (hold),
		.eligible  (eligible),
		.rateSel   (convRate_reg[`VM_RATE_PER_LSB +: 3]),
		.dlySel    (convRate_reg[`VM_RATE_DLY_LSB +: 4]),
		.convDone  (convDone),
		.convData  (convData),
		.convStart (convStart),
		.convChan  (convChan),
		.convHalf  (convHalf),
		.result    (result)
	);

	// event routing masks
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mgmtMaskLo_reg <= 8'h00;
			mgmtMaskHi_reg <= 8'h00;
			irqMaskLo_reg  <= 8'h00;
			irqMaskHi_reg  <= 8'h00;
		end else if (regWrEn) begin
			unique case (regAddr)
				`VM_OFS_MGMT_LO: mgmtMaskLo_reg <= regWrData;
				`VM_OFS_MGMT_HI: mgmtMaskHi_reg <= regWrData;
				`VM_OFS_IRQ_LO: irqMaskLo_reg <= regWrData;
				`VM_OFS_IRQ_HI: irqMaskHi_reg <= regWrData;
				default: begin
				end
			endcase
		end
	end

	// rate, configuration and bank select
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			convRate_reg <= `VM_RST_RATE;
			monCfg_reg   <= `VM_RST_CFG;
			bankSel_reg  <= 4'h0;
		end else if (regWrEn) begin
			unique case (regAddr)
				`VM_OFS_RATE: convRate_reg <= regWrData;
				`VM_OFS_CFG:  monCfg_reg   <= regWrData[2:0];
				`VM_OFS_BANK: bankSel_reg  <= regWrData[3:0];
				default: begin
				end
			endcase
		end
	end

	// channel configuration and sticky limit flags; hardware set wins over clear
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int c = 0; c < NCH; c++) begin
				chanCfg_reg[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (regWrEn && regAddr == `VM_OFS_CH_CFG && bankSel_reg == 4'(c)) begin
					chanCfg_reg[c].chanEn  <= regWrData[`VM_CH_EN];
					chanCfg_reg[c].alarmEn <= regWrData[`VM_CH_ALM_EN];
					if (regWrData[`VM_CH_HIGH_HIT]) begin
						chanCfg_reg[c].highHit <= 1'b0;
					end
					if (regWrData[`VM_CH_LOW_HIT]) begin
						chanCfg_reg[c].lowHit <= 1'b0;
					end
				end
				if (cmpPend_reg && cmpChan_reg == 4'(c)) begin
					if (hiViol) begin
						chanCfg_reg[c].highHit <= 1'b1;
					end
					if (loViol) begin
						chanCfg_reg[c].lowHit <= 1'b1;
					end
				end
			end
		end
	end

	// readouts are frozen while held so a failing supply cannot overwrite them
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int c = 0; c < NCH; c++) begin
				readout_reg[c] <= 8'h00;
			end
		end else if (result.valid && !hold) begin
			readout_reg[result.chan] <= result.data;
		end
	end

	// compare request follows each stored readout by one cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cmpPend_reg <= 1'b0;
			cmpChan_reg <= 4'h0;
		end else begin
			cmpPend_reg <= result.valid && !hold;
			cmpChan_reg <= result.chan;
		end
	end

	// high and low limits of the selected bank
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int c = 0; c < NCH; c++) begin
				highLim_reg[c] <= `VM_RST_HIGH;
				lowLim_reg[c]  <= `VM_RST_LOW;
			end
		end else if (regWrEn && bankOk) begin
			if (regAddr == `VM_OFS_CH_HIGH) begin
				highLim_reg[bankSel_reg] <= regWrData;
			end
			if (regAddr == `VM_OFS_CH_LOW) begin
				lowLim_reg[bankSel_reg] <= regWrData;
			end
		end
	end

	// outputs are registered; all low out of reset
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			alarmOut    <= 1'b0;
			sysMgmtInt  <= 1'b0;
			irqOut      <= 1'b0;
			refInternal <= 1'b0;
		end else begin
			alarmOut    <= |(alarmVec & almEnVec);
			sysMgmtInt  <= |(eventVec & {mgmtMaskHi_reg, mgmtMaskLo_reg});
			irqOut      <= |(eventVec & {irqMaskHi_reg, irqMaskLo_reg});
			refInternal <= monCfg_reg[`VM_CFG_INT_REF] || tempIntRef;
		end
	end

	// read decode of the sixteen-byte window; unused offsets read zero
	always_comb begin
		rdMux = 8'h00;
		unique case (regAddr)
			`VM_OFS_EVT_LO: rdMux = eventVec[7:0];
			`VM_OFS_EVT_HI: rdMux = eventVec[15:8];
			`VM_OFS_MGMT_LO: rdMux = mgmtMaskLo_reg;
			`VM_OFS_MGMT_HI: rdMux = mgmtMaskHi_reg;
			`VM_OFS_IRQ_LO: rdMux = irqMaskLo_reg;
			`VM_OFS_IRQ_HI: rdMux = irqMaskHi_reg;
			`VM_OFS_RATE:   rdMux = convRate_reg;
			`VM_OFS_CFG:    rdMux = {5'h00, monCfg_reg};
			`VM_OFS_BANK:   rdMux = {4'h0, bankSel_reg};
			`VM_OFS_CH_CFG: rdMux = bankOk ? cfgByte(chanCfg_reg[bankSel_reg]) : 8'h00;
			`VM_OFS_CH_READ: rdMux = bankOk ? readout_reg[bankSel_reg] : 8'h00;
			`VM_OFS_CH_HIGH: rdMux = bankOk ? highLim_reg[bankSel_reg] : 8'h00;
			`VM_OFS_CH_LOW:  rdMux = bankOk ? lowLim_reg[bankSel_reg] : 8'h00;
			default: rdMux = 8'h00;
		endcase
	end

	// read data lands one cycle after the strobe and then holds
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= rdMux;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_alarm_gate: assert property (##1 alarmOut == $past(|(alarmVec & almEnVec)))
		else $error("alarm output does not follow enabled limit flags");

	a_mgmt_gate: assert property (
		(eventVec & {mgmtMaskHi_reg, mgmtMaskLo_reg}) != 16'h0000 |=> sysMgmtInt)
		else $error("management interrupt missing for masked event");

	a_irq_gate: assert property (
		(eventVec & {irqMaskHi_reg, irqMaskLo_reg}) == 16'h0000 |=> !irqOut)
		else $error("irq raised without enabled event");

	a_sticky_high: assert property (
		bankOk && chanCfg_reg[bankSel_reg].highHit
		&& !(regWrEn && (regAddr == `VM_OFS_CH_CFG || regAddr == `VM_OFS_BANK))
		|=> chanCfg_reg[$past(bankSel_reg)].highHit)
		else $error("high limit flag dropped without a clear");

	a_readout_store: assert property (
		result.valid && !hold |=> readout_reg[$past(result.chan)] == $past(result.data))
		else $error("readout not stored for converted channel");

	a_cmp_high: assert property (
		result.valid && !hold && result.data > highLim_reg[result.chan]
		&& !(regWrEn && regAddr == `VM_OFS_CH_HIGH)
		|-> ##2 chanCfg_reg[$past(result.chan, 2)].highHit)
		else $error("high limit violation not flagged");

	// the channel index is the new one; only the eligibility vector is taken from the start edge
	a_skip_alarmed: assert property (
		convStart |-> |($past(eligible) & (NCH'(1) << convChan)))
		else $error("conversion started on ineligible channel");

	a_bank_reset: assert property ($rose(rst_b) |-> bankSel_reg == 4'h0 && !refInternal)
		else $error("bank select or reference not at default after reset");

	a_outputs_reset: assert property ($rose(rst_b) |-> !alarmOut && !sysMgmtInt && !irqOut)
		else $error("event outputs active after reset");

	a_ref_shared: assert property (tempIntRef |=> refInternal)
		else $error("internal reference not shared");

	c_burst_start: cover property (convStart ##[1:40] result.valid);
	c_alarm_rise: cover property ($rose(alarmOut));
	c_hold_in_burst: cover property (convStart ##1 hold);
	c_clear_flag: cover property ($fell(alarmVec[2]));

endmodule : voltage_level_monitor_ctrl
`default_nettype wire

// [bench/adc_model.sv]
// behavioural model of the converter that answers the monitor's start pulses
`timescale 1ns/10ps
`default_nettype none

module adc_model (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             convStart,
	input  wire logic [3:0]       convChan,
	input  wire logic [7:0]       latency,
	input  wire logic [10:0][7:0] chanVal,
	output logic                  convDone,
	output logic [7:0]            convData
);
	logic       busy;
	logic [7:0] cnt;
	logic [3:0] chan;

	// one conversion at a time; data line toggles outside the done cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			busy     <= 1'b0;
			cnt      <= 8'h00;
			chan     <= 4'h0;
			convDone <= 1'b0;
			convData <= 8'h00;
		end else begin
			convDone <= 1'b0;
			convData <= ~convData; // no stale value survives the done cycle
			if (convStart) begin
				busy <= 1'b1;
				cnt  <= latency;
				chan <= convChan;
			end else if (busy && cnt <= 8'h01) begin
				busy     <= 1'b0;
				convDone <= 1'b1;
				convData <= chanVal[chan];
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule : adc_model

`default_nettype wire

// [bench/tb_voltage_level_monitor_ctrl.sv]
// self-checking bench for the voltage monitor control block
`timescale 1ns/10ps
`default_nettype none

module tb_voltage_level_monitor_ctrl;
	import voltage_monitor_pkg::*;
	localparam int DLY = 2;
	logic clock = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00, regRdData, convData, latency = 8'h03;
	logic powerFailSense_b = 1'b1, errorDetect = 1'b0, tempIntRef = 1'b0;
	logic refInternal, convStart, convHalf, convDone, alarmOut, sysMgmtInt, irqOut;
	logic [3:0] convChan;
	logic [10:0][7:0] chanVal = '0;
	logic [4:0] started[$];
	int errors = 0, num_checks = 0, cyc = 0, doneAt = 0, gap = 0;

	voltage_level_monitor_ctrl #(.PERIOD_UNIT(400), .DLY_UNIT(DLY)) dut (
		.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.powerFailSense_b(powerFailSense_b), .errorDetect(errorDetect),
		.tempIntRef(tempIntRef), .refInternal(refInternal), .convStart(convStart),
		.convChan(convChan), .convHalf(convHalf), .convDone(convDone),
		.convData(convData), .alarmOut(alarmOut), .sysMgmtInt(sysMgmtInt), .irqOut(irqOut));

	adc_model adc (.clock(clock), .rst_b(rst_b), .convStart(convStart),
		.convChan(convChan), .latency(latency), .chanVal(chanVal),
		.convDone(convDone), .convData(convData));

	// 100 ns period
	always #50 clock = ~clock;

	// log each start and the spacing from the previous done
	always @(posedge clock) begin
		if (convDone)
			doneAt = cyc;
		if (convStart) begin
			started.push_back({convHalf, convChan});
			gap = cyc - doneAt;
		end
		cyc = cyc + 1;
	end

	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk8

	task automatic chk1(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask : chk1

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clock);
		#1 regWrEn = 1'b0;
	endtask : wr

	// data is loaded at the strobe edge and stands afterwards
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		#1 regAddr = a;
		regRdEn = 1'b1;
		@(posedge clock);
		#1 regRdEn = 1'b0;
		chk8($sformatf("reg %h", a), e, regRdData);
	endtask : rd

	task automatic setupCh(input logic [3:0] c, input logic [7:0] cfg, hi, lo);
		wr(4'h9, {4'h0, c});
		wr(4'ha, cfg);
		wr(4'hc, hi);
		wr(4'hd, lo);
	endtask : setupCh

	task automatic testReset();
		for (int i = 0; i < 16; i++)
			rd(i[3:0], (i == 12) ? 8'hff : 8'h00);
		chk1("alarmOut", 1'b0, alarmOut);
		chk1("sysMgmtInt", 1'b0, sysMgmtInt);
		chk1("irqOut", 1'b0, irqOut);
		chk1("refInternal", 1'b0, refInternal);
	endtask : testReset

	task automatic testRegs();
		wr(4'h9, 8'h03);
		rd(4'h9, 8'h03);
		wr(4'h2, 8'ha5);
		wr(4'h5, 8'h5a);
		rd(4'h2, 8'ha5);
		rd(4'h5, 8'h5a);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h00);
		wr(4'h9, 8'h0b);
		wr(4'hc, 8'h12);
		rd(4'hc, 8'h00);
		wr(4'h9, 8'h03);
		rd(4'hc, 8'hff);
		wr(4'h2, 8'h00);
		wr(4'h5, 8'h00);
	endtask : testRegs

	task automatic testRef();
		tempIntRef = 1'b1;
		repeat (3) @(posedge clock);
		chk1("refInternal", 1'b1, refInternal);
		#1 tempIntRef = 1'b0;
		wr(4'h8, 8'h04);
		repeat (3) @(posedge clock);
		chk1("refInternal", 1'b1, refInternal);
		wr(4'h8, 8'h00);
		repeat (3) @(posedge clock);
		chk1("refInternal", 1'b0, refInternal);
	endtask : testRef

	task automatic testScan();
		logic [4:0] order[5] = '{5'h00, 5'h02, 5'h05, 5'h17, 5'h09};
		logic [7:0] flags[5] = '{8'h01, 8'h43, 8'h01, 8'h01, 8'h81};
		chanVal[0] = 8'h40;
		chanVal[2] = 8'hf0;
		chanVal[5] = 8'h80;
		chanVal[7] = 8'h10;
		chanVal[9] = 8'h05;
		wr(4'h7, 8'h30);
		setupCh(4'h0, 8'h01, 8'hff, 8'h00);
		setupCh(4'h2, 8'h03, 8'h80, 8'h00);
		setupCh(4'h5, 8'h01, 8'h80, 8'h00);
		setupCh(4'h7, 8'h01, 8'hff, 8'h10);
		setupCh(4'h9, 8'h01, 8'hff, 8'h20);
		wr(4'h2, 8'h04);
		wr(4'h5, 8'h02);
		started.delete();
		wr(4'h8, 8'h01);
		repeat (300) @(posedge clock);
		chk8("starts", 8'd5, 8'(started.size()));
		for (int i = 0; i < 5; i++) begin
			chk8("order", {3'b000, order[i]}, {3'b000, started[i]});
			wr(4'h9, {4'h0, order[i][3:0]});
			rd(4'hb, chanVal[order[i][3:0]]);
			rd(4'ha, flags[i]);
		end
		chk8("settle", 8'(3 * DLY + 2), 8'(gap));
		rd(4'h0, 8'h04);
		rd(4'h1, 8'h02);
		chk1("alarmOut", 1'b1, alarmOut);
		chk1("sysMgmtInt", 1'b1, sysMgmtInt);
		chk1("irqOut", 1'b1, irqOut);
	endtask : testScan

	task automatic testSticky();
		chanVal[2] = 8'h50;
		chanVal[9] = 8'h30;
		latency = 8'h11;
		started.delete();
		repeat (400) @(posedge clock);
		chk8("starts", 8'd3, 8'(started.size()));
		chk8("skip", 8'h05, {3'b000, started[1]});
		wr(4'h9, 8'h02);
		rd(4'hb, 8'hf0);
		rd(4'ha, 8'h43);
		// host alarm response: events first, then clear per bank
		rd(4'h0, 8'h04);
		wr(4'ha, 8'h03);
		rd(4'ha, 8'h43);
		wr(4'ha, 8'h43);
		rd(4'ha, 8'h03);
		repeat (3) @(posedge clock);
		chk1("alarmOut", 1'b0, alarmOut);
		chk1("sysMgmtInt", 1'b0, sysMgmtInt);
		chk1("irqOut", 1'b1, irqOut);
		wr(4'h9, 8'h09);
		wr(4'ha, 8'h81);
		rd(4'h1, 8'h00);
		chk1("irqOut", 1'b0, irqOut);
		latency = 8'h03;
	endtask : testSticky

	task automatic testHold();
		for (int k = 0; k < 2; k++) begin
			powerFailSense_b = (k != 0);
			errorDetect = (k == 1);
			chanVal[0] = chanVal[0] + 8'h01;
			repeat (5) @(posedge clock);
			started.delete();
			repeat (500) @(posedge clock);
			chk8("held starts", 8'd0, 8'(started.size()));
			wr(4'h9, 8'h00);
			rd(4'hb, chanVal[0] - 8'h01);
			powerFailSense_b = 1'b1;
			errorDetect = 1'b0;
			repeat (500) @(posedge clock);
			#1 chk1("resumed", 1'b1, started.size() != 0);
		end
	endtask : testHold

	task automatic testStandby();
		wr(4'h8, 8'h03);
		repeat (100) @(posedge clock);
		started.delete();
		repeat (500) @(posedge clock);
		chk8("standby starts", 8'd0, 8'(started.size()));
		wr(4'h9, 8'h00);
		rd(4'hb, chanVal[0]);
		wr(4'h8, 8'h00);
	endtask : testStandby

	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// the whole run needs about 3500 cycles
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		results();
	end

	initial begin
		repeat (16) @(posedge clock);
		#1 rst_b = 1'b1;
		testReset();
		testRegs();
		testRef();
		testScan();
		testSticky();
		testHold();
		testStandby();
		results();
	end
endmodule : tb_voltage_level_monitor_ctrl

`default_nettype wire
